// >>> include/erm_cfg.svh
// Purpose: offsets, field positions, reset values and timing for the reset sequencer
// Assumes: 50 MHz core clock, word-aligned AHB-Lite registers
// Notes: times are in microseconds, cycle counts derive from them
`ifndef ERM_CFG_SVH
`define ERM_CFG_SVH
`define ERM_CLK_MHZ 50
`define ERM_TPUR_US 10000
`define ERM_FILT_US 16
`define ERM_WDRST_US 40
`define ERM_RAMP_US 20000
`define ERM_PD_UNIT_US 1000
`define ERM_OFF_CONFIG 8'h00
`define ERM_OFF_STATUS 8'h04
`define ERM_OFF_DIAG 8'h08
`define ERM_OFF_STAGE 8'h0c
`define ERM_OFF_CMD 8'h10
`define ERM_OFF_PDCNT 8'h14
`define ERM_CFG_PDT_LSB 0
`define ERM_CFG_PDT_W 4
`define ERM_CFG_AR_BIT 4
`define ERM_CFG_AE_BIT 5
`define ERM_CFG_WATCHDOG_RESET_ENABLE_BIT 6
`define ERM_CFG_DSO_BIT 7
`define ERM_CFG_RESET 8'h00
`define ERM_STAGE_RESET 28'h0000000
`define ERM_CMD_SWRST_BIT 0
`define ERM_ST_OM_BIT 0
`define ERM_ST_STATE_LSB 1
`define ERM_ST_ECUPOR_BIT 4
`define ERM_ST_RSTLOW_BIT 5
`define ERM_ST_WDRST_BIT 6
`define ERM_ST_WAKE_LSB 8
`endif

// >>> include/erm_pkg.sv
// Purpose: types shared by the reset and operation mode sequencer
// Assumes: nothing beyond the config header
// Notes: operation states of the supervisory machine
package erm_pkg;
   typedef enum logic [2:0] {
      ERM_SLEEP,
      ERM_RAMP,
      ERM_NORMAL,
      ERM_AFTERRUN,
      ERM_AR_RESET,
      ERM_PDOWN,
      ERM_WAKE_CLEAR
   } erm_state_e;
endpackage

// >>> verilog/erm_sequencer.sv
// Purpose: operation state machine, reset sources and reset pin drive of the supervisor
// Assumes: resetn is the internal power-on reset; pins and pulses are clk-synchronous
// Notes: registers on AHB-Lite, reads insert one wait state, writes none
//
// Overview of operation
// - wake-clear with key low goes to sleep, ignoring wake activity
// - wake-clear with key high goes to ramp-up, ignoring bus and pin wakes
// - wake is OR of three flags; key and wakes are filtered
// - status register bit shows normal operation or afterrun
// - power-down time comes from the config register field
// - internal power-on reset clears all; release goes to sleep or ramp-up
// - main and tracker supplies off until power-on; standby and pre-regulator always on
// - ECU power-on reset drives both pins low, releases delay after supply recovers
// - main undervoltage holds pins low, keeps delayed switch-off, sets relay from key or local wake unless battery low
// - tracker faults only set diagnosis bits
// - main overvoltage disables all external functions and holds pins low
// - battery overvoltage disables all power stages
// - enabled watchdog reset drives micro pin low, stages off, bus receive-only
// - software reset command resets device and bumps power-down counter
// - both pins bidirectional; external low on micro pin resets device
// - external low on monitor pin clears all stage enable bits
// - fast serial link timeout clears all stage enable bits
// - afterrun reset when bit set and afterrun-to-normal is triggered
// - afterrun reset state moves to normal on the next clock
// - power-down timer overflow goes to wake-clear and clears wake flags
`include "erm_cfg.svh"
module erm_sequencer
   import erm_pkg::*;
#(
   parameter int TPUR_CYC = `ERM_TPUR_US * `ERM_CLK_MHZ,
   parameter int RAMP_CYC = `ERM_RAMP_US * `ERM_CLK_MHZ,
   parameter int PD_UNIT_CYC = `ERM_PD_UNIT_US * `ERM_CLK_MHZ,
   parameter int FILT_CYC = `ERM_FILT_US * `ERM_CLK_MHZ,
   parameter int WDRST_CYC = `ERM_WDRST_US * `ERM_CLK_MHZ
)
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic key_above_th,
   input wire logic main_5v_uv,
   input wire logic main_5v_above_hyst,
   input wire logic main_5v_ov,
   input wire logic tracker_one_uv,
   input wire logic tracker_one_ov,
   input wire logic tracker_two_uv,
   input wire logic tracker_two_ov,
   input wire logic battery_ov,
   input wire logic battery_low,
   input wire logic local_wake_pin,
   input wire logic bus_wake_in,
   input wire logic timed_wake_in,
   input wire logic pd_counter_of,
   input wire logic secure_off_of,
   input wire logic wd_reset_inc,
   input wire logic serial_timeout,
   input wire logic micro_reset_pin_i,
   output logic micro_reset_pin_o,
   output logic micro_reset_pin_oe_n,
   input wire logic monitor_reset_pin_i,
   output logic monitor_reset_pin_o,
   output logic monitor_reset_pin_oe_n,
   output logic main_5v_en,
   output logic tracker_en,
   output logic standby_5v_en,
   output logic pre_regulator_6v_en,
   output logic [27:0] stage_en,
   output logic lin_can_rx_only,
   output logic lin_can_dis,
   output logic serial_dis,
   output logic main_relay,
   output logic delayed_off_active,
   output logic operating_mode
);

   ////////////////////////////////////////////////////////////////////////////////
   // comparator synchroniser

   localparam int NSYNC = 10;
   logic [NSYNC-1:0] sync1_q;
   logic [NSYNC-1:0] sync2_q;
   logic key_s;
   logic uv_s;
   logic hyst_s;
   logic ov_s;
   logic t1uv_s;
   logic t1ov_s;
   logic t2uv_s;
   logic t2ov_s;
   logic batov_s;
   logic batlow_s;

   // two flops, only the second is read
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sync1_q <= '0;
         sync2_q <= '0;
      end
      else
      begin
         sync1_q <= {key_above_th, main_5v_uv, main_5v_above_hyst, main_5v_ov,
                     tracker_one_uv, tracker_one_ov, tracker_two_uv, tracker_two_ov,
                     battery_ov, battery_low};
         sync2_q <= sync1_q;
      end
   end
   assign {key_s, uv_s, hyst_s, ov_s, t1uv_s, t1ov_s, t2uv_s, t2ov_s, batov_s, batlow_s} =
      sync2_q;

   ////////////////////////////////////////////////////////////////////////////////
   // filters on key and wake sources

   logic [3:0] filt_raw;
   logic [3:0] filt_q;
   assign filt_raw = {key_s, local_wake_pin, bus_wake_in, timed_wake_in};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_filt
         logic [15:0] cnt_q;
         logic [15:0] cnt_d;
         logic out_d;
         // output follows input once it differs for the filter time
         always_comb
         begin
            cnt_d = 16'h0000;
            out_d = filt_q[gi];
            if (filt_raw[gi] != filt_q[gi])
            begin
               if (cnt_q == 16'(FILT_CYC - 1))
                  out_d = filt_raw[gi];
               else
                  cnt_d = cnt_q + 16'h0001;
            end
         end
         always_ff @(posedge clk or negedge resetn)
         begin
            if (!resetn)
            begin
               cnt_q <= 16'h0000;
               filt_q[gi] <= 1'b0;
            end
            else
            begin
               cnt_q <= cnt_d;
               filt_q[gi] <= out_d;
            end
         end
      end
   endgenerate

   logic key_f;
   logic lwake_f;
   assign key_f = filt_q[3];
   assign lwake_f = filt_q[2];

   ////////////////////////////////////////////////////////////////////////////////
   // state, timers, registers and pin drive

   erm_state_e state_q, state_d;
   logic [2:0] wake_q, wake_d;
   logic [23:0] tmr_q, tmr_d;
   logic ecu_por_q, ecu_por_d;
   logic [23:0] por_cnt_q, por_cnt_d;
   logic [15:0] wd_cnt_q, wd_cnt_d;
   logic wd_rst_q, wd_rst_d;
   logic [7:0] cfg_q, cfg_d;
   logic [27:0] stage_q, stage_d;
   logic [6:0] diag_q, diag_d;
   logic [7:0] pdcnt_q, pdcnt_d;
   logic rst_low_q, rst_low_d;
   logic mon_low_q, mon_low_d;
   logic rst_guard_q;
   logic mon_guard_q;
   logic wr_pend_q, wr_pend_d;
   logic rd_pend_q, rd_pend_d;
   logic [7:0] addr_q, addr_d;
   logic [31:0] hrdata_d;
   logic hready_d;
   logic wake_any;
   logic active;
   logic pd_end;
   logic wr_en;
   logic sw_rst;
   logic rst_ext;
   logic mon_ext;
   logic dev_clr;
   logic stage_gate;
   logic [23:0] pd_limit;

   assign wake_any = |wake_q;
   assign active = (state_q != ERM_SLEEP);
   assign pd_limit = 24'(PD_UNIT_CYC) *
      {20'h00000, cfg_q[`ERM_CFG_PDT_LSB +: `ERM_CFG_PDT_W]} + 24'(PD_UNIT_CYC);
   assign pd_end = (tmr_q >= pd_limit - 24'h000001);
   assign wr_en = wr_pend_q;
   assign sw_rst = wr_en && (addr_q == `ERM_OFF_CMD) && hwdata[`ERM_CMD_SWRST_BIT];
   // external low seen only when our own drive has been off for a cycle
   assign rst_ext = !micro_reset_pin_i && !rst_low_q && !rst_guard_q;
   assign mon_ext = !monitor_reset_pin_i && !mon_low_q && !mon_guard_q;
   assign dev_clr = ecu_por_q || sw_rst || rst_ext || (state_q == ERM_AR_RESET) ||
      (active && uv_s);
   assign stage_gate = !ov_s && !batov_s && !wd_rst_q &&
      ((state_q == ERM_NORMAL) || (state_q == ERM_AFTERRUN));

   // next operation state
   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         ERM_SLEEP:
            if (key_f || wake_any)
               state_d = ERM_RAMP;
         ERM_RAMP:
            if (!key_f && !wake_any)
               state_d = ERM_SLEEP;
            else if (!key_f && tmr_q == 24'(RAMP_CYC - 1))
               state_d = ERM_WAKE_CLEAR;
            else if (!uv_s)
               state_d = ERM_NORMAL;
         ERM_NORMAL:
            if ((pd_counter_of || secure_off_of) && !key_f)
               state_d = ERM_PDOWN;
            else if (!key_f && cfg_q[`ERM_CFG_AE_BIT])
               state_d = ERM_AFTERRUN;
            else if (!key_f && !wake_any && !cfg_q[`ERM_CFG_AE_BIT])
               state_d = ERM_SLEEP;
         ERM_AFTERRUN:
            if (pd_counter_of || secure_off_of)
               state_d = ERM_PDOWN;
            else if (!key_f && !wake_any && !cfg_q[`ERM_CFG_AE_BIT])
               state_d = ERM_SLEEP;
            else if (key_f && cfg_q[`ERM_CFG_AR_BIT])
               state_d = ERM_AR_RESET;
            else if (key_f)
               state_d = ERM_NORMAL;
         ERM_AR_RESET:
            state_d = ERM_NORMAL;
         ERM_PDOWN:
            if (pd_end)
               state_d = ERM_WAKE_CLEAR;
         ERM_WAKE_CLEAR:
            state_d = key_f ? ERM_RAMP : ERM_SLEEP;
         default:
            state_d = ERM_SLEEP;
      endcase
   end

   // timers, wake flags, resets, registers and bus
   always_comb
   begin
      tmr_d = (state_d == state_q) ? tmr_q + 24'h000001 : 24'h000000;
      // wakes are latched; held clear in wake-clear, on overflow and at undervoltage while active
      wake_d = wake_q | filt_q[2:0];
      if ((state_q == ERM_WAKE_CLEAR) || (state_q == ERM_PDOWN && pd_end) || (active && uv_s))
         wake_d = 3'b000;
      // ECU power-on reset armed by ramp-up to normal
      ecu_por_d = ecu_por_q;
      por_cnt_d = 24'h000000;
      if (state_q == ERM_RAMP && state_d == ERM_NORMAL)
         ecu_por_d = 1'b1;
      else if (ecu_por_q && hyst_s)
      begin
         if (por_cnt_q == 24'(TPUR_CYC - 1))
            ecu_por_d = 1'b0;
         else
            por_cnt_d = por_cnt_q + 24'h000001;
      end
      // watchdog reset pulse
      wd_rst_d = wd_rst_q;
      wd_cnt_d = 16'h0000;
      if (wd_reset_inc && cfg_q[`ERM_CFG_WATCHDOG_RESET_ENABLE_BIT])
         wd_rst_d = 1'b1;
      else if (wd_rst_q)
      begin
         if (wd_cnt_q == 16'(WDRST_CYC - 1))
            wd_rst_d = 1'b0;
         else
            wd_cnt_d = wd_cnt_q + 16'h0001;
      end
      // pin drive
      rst_low_d = ecu_por_d || (active && uv_s) || ov_s || wd_rst_d;
      mon_low_d = ecu_por_d || (active && uv_s) || ov_s;
      // diagnosis flags, set wins over write-one-clear
      diag_d = diag_q;
      if (wr_en && addr_q == `ERM_OFF_DIAG)
         diag_d = diag_q & ~hwdata[6:0];
      diag_d = diag_d | {batov_s, t2ov_s, t2uv_s, t1ov_s, t1uv_s, ov_s, uv_s};
      // config and stage enables
      cfg_d = cfg_q;
      stage_d = stage_q;
      if (wr_en && addr_q == `ERM_OFF_CONFIG)
         cfg_d = hwdata[7:0];
      if (wr_en && addr_q == `ERM_OFF_STAGE)
         stage_d = hwdata[27:0];
      if (dev_clr)
      begin
         cfg_d = `ERM_CFG_RESET;
         stage_d = `ERM_STAGE_RESET;
      end
      // undervoltage keeps the delayed switch-off setup so the function stays active
      if (active && uv_s)
         cfg_d[`ERM_CFG_DSO_BIT] = cfg_q[`ERM_CFG_DSO_BIT];
      if (mon_ext || serial_timeout)
         stage_d = `ERM_STAGE_RESET;
      pdcnt_d = pdcnt_q;
      if (ecu_por_q)
         pdcnt_d = 8'h00;
      else if (sw_rst)
         pdcnt_d = pdcnt_q + 8'h01;
      // bus: writes take data phase next cycle, reads one wait state
      wr_pend_d = 1'b0;
      rd_pend_d = 1'b0;
      addr_d = addr_q;
      hready_d = 1'b1;
      hrdata_d = hrdata;
      if (hsel && htrans[1] && hready)
      begin
         addr_d = {haddr[7:2], 2'b00};
         wr_pend_d = hwrite;
         rd_pend_d = !hwrite;
         hready_d = hwrite;
      end
      if (rd_pend_q)
      begin
         unique case (addr_q)
            `ERM_OFF_CONFIG: hrdata_d = {24'h000000, cfg_q};
            `ERM_OFF_STATUS: hrdata_d = {21'h000000, wake_q, 1'b0, wd_rst_q, rst_low_q,
               ecu_por_q, 3'(state_q), state_q == ERM_AFTERRUN};
            `ERM_OFF_DIAG: hrdata_d = {25'h0000000, diag_q};
            `ERM_OFF_STAGE: hrdata_d = {4'h0, stage_q};
            `ERM_OFF_PDCNT: hrdata_d = {24'h000000, pdcnt_q};
            default: hrdata_d = 32'h00000000;
         endcase
      end
   end

   // register everything
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_q <= ERM_SLEEP;
         wake_q <= 3'b000;
         tmr_q <= 24'h000000;
         ecu_por_q <= 1'b0;
         por_cnt_q <= 24'h000000;
         wd_rst_q <= 1'b0;
         wd_cnt_q <= 16'h0000;
         cfg_q <= `ERM_CFG_RESET;
         stage_q <= `ERM_STAGE_RESET;
         diag_q <= 7'h00;
         pdcnt_q <= 8'h00;
         rst_low_q <= 1'b1;
         mon_low_q <= 1'b1;
         rst_guard_q <= 1'b1;
         mon_guard_q <= 1'b1;
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         addr_q <= 8'h00;
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         wake_q <= wake_d;
         tmr_q <= tmr_d;
         ecu_por_q <= ecu_por_d;
         por_cnt_q <= por_cnt_d;
         wd_rst_q <= wd_rst_d;
         wd_cnt_q <= wd_cnt_d;
         cfg_q <= cfg_d;
         stage_q <= stage_d;
         diag_q <= diag_d;
         pdcnt_q <= pdcnt_d;
         rst_low_q <= rst_low_d;
         mon_low_q <= mon_low_d;
         rst_guard_q <= rst_low_q;
         mon_guard_q <= mon_low_q;
         wr_pend_q <= wr_pend_d;
         rd_pend_q <= rd_pend_d;
         addr_q <= addr_d;
         hrdata <= hrdata_d;
         hreadyout <= hready_d;
         hresp <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // registered external controls

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         micro_reset_pin_o <= 1'b0;
         micro_reset_pin_oe_n <= 1'b0;
         monitor_reset_pin_o <= 1'b0;
         monitor_reset_pin_oe_n <= 1'b0;
         main_5v_en <= 1'b0;
         tracker_en <= 1'b0;
         standby_5v_en <= 1'b1;
         pre_regulator_6v_en <= 1'b1;
         stage_en <= 28'h0000000;
         lin_can_rx_only <= 1'b0;
         lin_can_dis <= 1'b1;
         serial_dis <= 1'b1;
         main_relay <= 1'b0;
         delayed_off_active <= 1'b0;
         operating_mode <= 1'b0;
      end
      else
      begin
         micro_reset_pin_o <= 1'b0;
         micro_reset_pin_oe_n <= !rst_low_d;
         monitor_reset_pin_o <= 1'b0;
         monitor_reset_pin_oe_n <= !mon_low_d;
         main_5v_en <= (state_d != ERM_SLEEP);
         tracker_en <= (state_d != ERM_SLEEP);
         standby_5v_en <= 1'b1;
         pre_regulator_6v_en <= 1'b1;
         stage_en <= stage_gate ? stage_q : 28'h0000000;
         lin_can_rx_only <= wd_rst_q || ecu_por_q || (active && uv_s);
         lin_can_dis <= ov_s || !active;
         serial_dis <= ov_s;
         main_relay <= (active && uv_s) ? ((key_f || lwake_f) && !batlow_s) : active;
         delayed_off_active <= active && uv_s && cfg_q[`ERM_CFG_DSO_BIT];
         operating_mode <= (state_q == ERM_AFTERRUN);
      end
   end

endmodule

// >>> sim/erm_reset_partner.sv
// Purpose: engine micro and attached devices on the two reset lines
// Assumes: both lines carry a pull-up to the 5V rail
// Notes: a released line reads high unless some party pulls it low
module erm_reset_partner
(
   input wire logic micro_o,
   input wire logic micro_oe_n,
   input wire logic monitor_o,
   input wire logic monitor_oe_n,
   input wire logic micro_pull_low,
   input wire logic monitor_pull_low,
   output logic micro_line,
   output logic monitor_line
);
   timeunit 1ns;
   timeprecision 1ps;
   // wired-and of the device drive and the outside drive over the pull-up
   assign micro_line = !((!micro_oe_n && !micro_o) || micro_pull_low);
   assign monitor_line = !((!monitor_oe_n && !monitor_o) || monitor_pull_low);
endmodule

// >>> sim/erm_sequencer_sva.sv
// Purpose: port-level checks on the reset and operation mode sequencer
// Assumes: one clock domain, resetn active low
// Notes: fault flags need a few cycles to pass the synchronisers
module erm_sequencer_sva
   import erm_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic main_5v_uv,
   input wire logic main_5v_ov,
   input wire logic battery_ov,
   input wire logic serial_timeout,
   input wire logic micro_reset_pin_i,
   input wire logic micro_reset_pin_oe_n,
   input wire logic monitor_reset_pin_i,
   input wire logic monitor_reset_pin_oe_n,
   input wire logic main_5v_en,
   input wire logic tracker_en,
   input wire logic standby_5v_en,
   input wire logic pre_regulator_6v_en,
   input wire logic [27:0] stage_en,
   input wire logic lin_can_dis,
   input wire logic serial_dis
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking dck @(posedge clk);
   endclocking
   default disable iff (!resetn);

   // outside lows seen while the device leaves the line released
   sequence mon_forced;
      (!monitor_reset_pin_i && monitor_reset_pin_oe_n) [*5];
   endsequence
   sequence micro_forced;
      (!micro_reset_pin_i && micro_reset_pin_oe_n) [*5];
   endsequence

   aux_supply_on_a: assert property (standby_5v_en && pre_regulator_6v_en)
      else $error("standby supplies off");
   supply_pair_a: assert property (main_5v_en == tracker_en)
      else $error("main and tracker enables differ");
   supply_release_a: assert property ($rose(resetn) |-> !main_5v_en)
      else $error("main supply on at reset release");
   pins_pair_a: assert property (!monitor_reset_pin_oe_n |-> !micro_reset_pin_oe_n)
      else $error("monitor pin low without micro pin");
   ov_shutdown_a: assert property (main_5v_ov [*4] |->
      !micro_reset_pin_oe_n && !monitor_reset_pin_oe_n && serial_dis && lin_can_dis)
      else $error("overvoltage did not shut down");
   bat_ov_stages_a: assert property (battery_ov [*4] |-> stage_en == '0)
      else $error("stages on at battery overvoltage");
   uv_pins_low_a: assert property ((main_5v_uv && main_5v_en) [*4] |->
      !micro_reset_pin_oe_n && !monitor_reset_pin_oe_n)
      else $error("pins released at undervoltage");
   timeout_clear_a: assert property (serial_timeout [*3] |-> stage_en == '0)
      else $error("stages on after link timeout");
   mon_clear_a: assert property (mon_forced |-> stage_en == '0)
      else $error("stages on after monitor low");
   micro_clear_a: assert property (micro_forced |-> stage_en == '0)
      else $error("stages on after micro pin low");
endmodule

bind erm_sequencer erm_sequencer_sva i_erm_sequencer_sva (.clk(clk), .resetn(resetn),
   .main_5v_uv(main_5v_uv), .main_5v_ov(main_5v_ov), .battery_ov(battery_ov),
   .serial_timeout(serial_timeout), .micro_reset_pin_i(micro_reset_pin_i),
   .micro_reset_pin_oe_n(micro_reset_pin_oe_n), .monitor_reset_pin_i(monitor_reset_pin_i),
   .monitor_reset_pin_oe_n(monitor_reset_pin_oe_n), .main_5v_en(main_5v_en),
   .tracker_en(tracker_en), .standby_5v_en(standby_5v_en),
   .pre_regulator_6v_en(pre_regulator_6v_en), .stage_en(stage_en),
   .lin_can_dis(lin_can_dis), .serial_dis(serial_dis));

// >>> sim/tb.sv
// Purpose: self-checking bench for the reset and operation mode sequencer
// Assumes: short counts for the long supervision timers
// Notes: reset lines are resolved by the partner model with pull-ups
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TPUR = 20;
   localparam int WDRST = 5;
   typedef struct packed {logic [7:0] a; logic [31:0] wd; logic [31:0] exp;} erm_row_s;
   logic clk, resetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [7:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, rd;
   logic key_above_th, main_5v_uv, main_5v_above_hyst, main_5v_ov, battery_ov, battery_low;
   logic tracker_one_uv, tracker_one_ov, tracker_two_uv, tracker_two_ov, pd_counter_of;
   logic local_wake_pin, bus_wake_in, timed_wake_in, secure_off_of, wd_reset_inc;
   logic serial_timeout, micro_reset_pin_i, micro_reset_pin_o, micro_reset_pin_oe_n;
   logic monitor_reset_pin_i, monitor_reset_pin_o, monitor_reset_pin_oe_n, main_5v_en;
   logic tracker_en, standby_5v_en, pre_regulator_6v_en, lin_can_rx_only, lin_can_dis;
   logic serial_dis, main_relay, delayed_off_active, operating_mode, micro_pull, mon_pull;
   logic [27:0] stage_en;
   int n_errors = 0;
   int compares = 0;
   int cycles = 0;
   int cnt;
   // register rows: write value and what reads back
   erm_row_s rows [0:7] = '{
      '{8'h00, 32'hffffffff, 32'h000000ff}, '{8'h00, 32'h0, 32'h0},
      '{8'h0c, 32'hffffffff, 32'h0fffffff}, '{8'h0c, 32'h00a5a5a5, 32'h00a5a5a5},
      '{8'h04, 32'hffffffff, 32'h4}, '{8'h14, 32'hff, 32'h0},
      '{8'h08, 32'h7f, 32'h0}, '{8'h1c, 32'hffffffff, 32'h0}};

   assign hready = hreadyout;
   erm_sequencer #(.TPUR_CYC(TPUR), .RAMP_CYC(40), .PD_UNIT_CYC(10), .FILT_CYC(2),
      .WDRST_CYC(WDRST)) i_erm_sequencer (.*);
   erm_reset_partner i_erm_reset_partner (.micro_o(micro_reset_pin_o),
      .micro_oe_n(micro_reset_pin_oe_n), .monitor_o(monitor_reset_pin_o),
      .monitor_oe_n(monitor_reset_pin_oe_n), .micro_pull_low(micro_pull),
      .monitor_pull_low(mon_pull), .micro_line(micro_reset_pin_i),
      .monitor_line(monitor_reset_pin_i));

   ////////////////////////////////////////
   // clock and hang guard
   initial clk = 1'b0;
   always #10 clk = ~clk;
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_errors++;
         finish_test();
      end
   end

   task automatic finish_test();
      if (n_errors == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // one single AHB-Lite transfer; read data lands in rd
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask

   task automatic chk_reg(input string n, input logic [7:0] a, input logic [31:0] m,
                          input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      check(n, rd & m, exp);
   endtask

   ////////////////////////////////////////
   // main sequence
   initial
   begin
      {hwrite, key_above_th, main_5v_uv, main_5v_above_hyst, main_5v_ov, battery_ov} = '0;
      {battery_low, tracker_one_uv, tracker_one_ov, tracker_two_uv, tracker_two_ov} = '0;
      {local_wake_pin, bus_wake_in, timed_wake_in, pd_counter_of, secure_off_of} = '0;
      {wd_reset_inc, serial_timeout, micro_pull, mon_pull, resetn} = '0;
      hsel = 1'b1;
      htrans = 2'h0;
      hsize = 3'h2;
      haddr = 8'h00;
      hwdata = 32'h0;
      cyc(11);
      check("pins in reset", {micro_reset_pin_oe_n, monitor_reset_pin_oe_n}, 0);
      check("aux supplies", {standby_5v_en, pre_regulator_6v_en}, 2'b11);
      check("main supplies", {main_5v_en, tracker_en}, 0);
      cyc(1);
      resetn <= 1'b1;
      cyc(10);
      check("sleep supply", main_5v_en, 0);
      // key up: power-on reset must wait for the main supply level
      key_above_th <= 1'b1;
      while (main_5v_en !== 1'b1) @(posedge clk);
      while (micro_reset_pin_oe_n !== 1'b0) @(posedge clk);
      cyc(30);
      check("por held", {micro_reset_pin_oe_n, monitor_reset_pin_oe_n}, 0);
      main_5v_above_hyst <= 1'b1;
      cnt = 0;
      while (micro_reset_pin_oe_n !== 1'b1)
      begin
         @(posedge clk);
         cnt++;
      end
      check("por length", 32'(cnt >= TPUR && cnt <= TPUR + 4), 1);
      chk_reg("status", 8'h04, '1, 32'h4);
      foreach (rows[i])
      begin
         xfer(1'b1, rows[i].a, rows[i].wd);
         chk_reg("register", rows[i].a, '1, rows[i].exp);
      end
      // software reset clears setup and counts once
      xfer(1'b1, 8'h00, 32'h40);
      xfer(1'b1, 8'h10, 32'h1);
      while (micro_reset_pin_oe_n !== 1'b1) @(posedge clk);
      chk_reg("pd count", 8'h14, '1, 32'h1);
      chk_reg("config after command", 8'h00, '1, 32'h0);
      // outside low on the monitor line, then the micro re-enables
      xfer(1'b1, 8'h0c, 32'hff);
      mon_pull <= 1'b1;
      cyc(6);
      mon_pull <= 1'b0;
      chk_reg("stages after monitor", 8'h0c, '1, 32'h0);
      xfer(1'b1, 8'h0c, 32'hff);
      chk_reg("stages re-enabled", 8'h0c, '1, 32'hff);
      // tracker faults only flag diagnosis
      {tracker_one_uv, tracker_one_ov, tracker_two_uv, tracker_two_ov} <= 4'hf;
      cyc(8);
      check("tracker pin", micro_reset_pin_oe_n, 1);
      check("tracker stages", stage_en, 28'hff);
      {tracker_one_uv, tracker_one_ov, tracker_two_uv, tracker_two_ov} <= 4'h0;
      chk_reg("diag", 8'h08, '1, 32'h3c);
      xfer(1'b1, 8'h08, 32'h3c);
      chk_reg("diag cleared", 8'h08, '1, 32'h0);
      serial_timeout <= 1'b1;
      cyc(3);
      serial_timeout <= 1'b0;
      check("stages after timeout", stage_en, 0);
      // watchdog reset with the enable set
      xfer(1'b1, 8'h00, 32'h40);
      xfer(1'b1, 8'h0c, 32'hff);
      wd_reset_inc <= 1'b1;
      cyc(1);
      wd_reset_inc <= 1'b0;
      cnt = 0;
      repeat (20)
      begin
         @(posedge clk);
         if (micro_reset_pin_oe_n === 1'b0)
            cnt++;
         if (cnt == 2)
            check("watchdog", {lin_can_rx_only, monitor_reset_pin_oe_n, stage_en}, 30'h3 << 28);
      end
      check("watchdog pulse", cnt, WDRST);
      micro_pull <= 1'b1;
      cyc(6);
      micro_pull <= 1'b0;
      chk_reg("config after pin", 8'h00, '1, 32'h0);
      // afterrun and re-entry with reset
      xfer(1'b1, 8'h00, 32'h30);
      key_above_th <= 1'b0;
      cyc(20);
      chk_reg("afterrun status", 8'h04, 32'hf, 32'h7);
      check("afterrun mode", operating_mode, 1);
      key_above_th <= 1'b1;
      cyc(20);
      chk_reg("normal again", 8'h04, 32'hf, 32'h4);
      chk_reg("config cleared", 8'h00, '1, 32'h0);
      // power-down for two units, then wake-clear and sleep
      xfer(1'b1, 8'h00, 32'h1);
      pd_counter_of <= 1'b1;
      key_above_th <= 1'b0;
      do xfer(1'b0, 8'h04, 32'h0); while ((rd & 32'he) !== 32'ha);
      cyc(10);
      chk_reg("power-down hold", 8'h04, 32'he, 32'ha);
      cyc(15);
      check("asleep", main_5v_en, 0);
      pd_counter_of <= 1'b0;
      // supply faults in normal operation
      key_above_th <= 1'b1;
      do xfer(1'b0, 8'h04, 32'h0); while (rd !== 32'h4);
      xfer(1'b1, 8'h0c, 32'hff);
      battery_ov <= 1'b1;
      cyc(6);
      check("battery fault", stage_en, 0);
      battery_ov <= 1'b0;
      main_5v_ov <= 1'b1;
      cyc(6);
      check("overvoltage", {micro_reset_pin_oe_n, monitor_reset_pin_oe_n, serial_dis}, 1);
      check("overvoltage stages", {lin_can_dis, stage_en}, 29'h1 << 28);
      main_5v_ov <= 1'b0;
      xfer(1'b1, 8'h00, 32'h80);
      main_5v_uv <= 1'b1;
      cyc(6);
      check("undervoltage", {micro_reset_pin_oe_n, monitor_reset_pin_oe_n}, 0);
      check("relay and switch-off", {main_relay, delayed_off_active}, 2'b11);
      finish_test();
   end
endmodule
